// ---- bench/sio_assertions.sv ----
// Checker for the status indicator outputs.
// Bound to sio_status_ind; one clock domain.
`default_nettype none
module sio_chk(input wire ref_clk, reset, powered_on, lte_registered, report_serial, report_usb_cmd,
	input wire report_usb_modem, cfg_wr, input wire [2:0] act_state, input wire [1:0] cfg_ring_mode,
	input wire registration_mode_indicator, activity_blink_output, operation_status_output,
	input wire ring_indicator_output, input wire [1:0] report_port_sel);
	timeunit 1ns;
	timeprecision 1ns;
	reg [1:0] rm_q;
	wire rep = report_serial | report_usb_cmd | report_usb_modem;
	always @(posedge ref_clk or posedge reset)
		if (reset) rm_q <= 2'h0;
		else if (cfg_wr) rm_q <= cfg_ring_mode;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence ring_held_low;
		!ring_indicator_output [*8];
	endsequence
	a_mode_level: assert property (1 |=> registration_mode_indicator == $past(powered_on && lte_registered))
		else $error("mode indicator wrong");
	a_status_level: assert property (1 |=> operation_status_output == $past(powered_on))
		else $error("status output wrong");
	a_ring_pulse: assert property (rep && rm_q != 2'h1 && rm_q != 2'h2 |=> ring_held_low)
		else $error("ring pulse missing");
	a_ring_cfg: assert property ((rm_q == 2'h1) [*2] |=> ring_indicator_output)
		else $error("ring not held high");
	a_ring_idle: assert property ($rose(ring_indicator_output) |-> !$past(rep))
		else $error("ring rose after report");
	a_voice_high: assert property ((powered_on && act_state == 3'h4) [*2] |-> activity_blink_output)
		else $error("voice not high");
	a_blink_restart: assert property (powered_on && act_state != $past(act_state) && act_state inside {[3'h1:3'h4]}
		|=> activity_blink_output)
		else $error("pattern not restarted");
	a_port_legal: assert property (report_port_sel != 2'h3)
		else $error("illegal port select");
endmodule
bind sio_status_ind sio_chk u_chk(.*);
`default_nettype wire

// ---- bench/sio_led_host.sv ----
// Host and LED model: measures run lengths of the indicators.
// Assumes the same clock as the design.
`default_nettype none
module sio_led_host(input wire ref_clk, input wire blink, input wire ring,
	output int hi_n, output int lo_n, output int ri_n);
	timeunit 1ns;
	timeprecision 1ns;
	int h = 0, l = 0, r = 0;
	always @(posedge ref_clk) begin
		if (blink) begin
			h++;
			if (l) lo_n = l;
			l = 0;
		end else begin
			l++;
			if (h) hi_n = h;
			h = 0;
		end
		if (!ring) r++;
		else begin
			if (r) ri_n = r;
			r = 0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Testbench for the status indicator outputs.
// Design built with TICK_CYCLES=10, so 1 ms is 10 cycles.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, reset = 1, powered_on = 0, lte_registered = 0, cfg_wr = 0;
	logic report_serial = 0, report_usb_cmd = 0, report_usb_modem = 0;
	logic [2:0] act_state = 0;
	logic [1:0] cfg_port = 0, cfg_ring_mode = 0;
	wire registration_mode_indicator, activity_blink_output, operation_status_output, ring_indicator_output;
	wire [1:0] report_port_sel;
	int fail_count = 0, n_compared = 0, cycles = 0, hi_n, lo_n, ri_n;
	sio_status_ind #(.TICK_CYCLES(10)) uut(.*);
	sio_led_host u_host(.ref_clk, .blink(activity_blink_output), .ring(ring_indicator_output), .hi_n, .lo_n, .ri_n);
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (++cycles == 99000) begin
		fail_count++;
		close_out;
	end
	task close_out;
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task levels;
		for (int i = 0; i < 4; i++) begin
			{powered_on, lte_registered} = i[1:0];
			cyc(2);
			chk(registration_mode_indicator, i == 3);
			chk(operation_status_output, i[1]);
		end
	endtask
	task cfg;
		cfg_wr = 1; cfg_port = 3; cfg_ring_mode = 1;
		cyc(1);
		cfg_wr = 0;
		cyc(2);
		chk(report_port_sel, 1);
		report_serial = 1;
		cyc(1);
		report_serial = 0;
		cyc(2);
		chk(ring_indicator_output, 1);
		cfg_wr = 1; cfg_port = 3; cfg_ring_mode = 2;
		cyc(1);
		cfg_wr = 0;
		cyc(2);
		chk(ring_indicator_output, 0);
		cfg_wr = 1; cfg_port = 2; cfg_ring_mode = 0;
		cyc(1);
		cfg_wr = 0;
		cyc(2);
		chk(report_port_sel, 2);
	endtask
	// Second strobe mid-pulse must stretch the low time
	task ring(input int gap);
		report_usb_cmd = 1;
		cyc(1);
		report_usb_cmd = 0;
		chk(ring_indicator_output, 0);
		if (gap) begin
			cyc(gap);
			{report_serial, report_usb_modem} = 2'h3;
			cyc(1);
			{report_serial, report_usb_modem} = 2'h0;
		end
		cyc(1300);
		chk(ri_n >= gap + 1199 && ri_n <= gap + 1212, 1);
		chk(ring_indicator_output, 1);
	endtask
	// First period may be short; the second is measured
	task blink(input logic [2:0] s, input int hi, input int lo);
		act_state = s;
		cyc(1);
		chk(activity_blink_output, 1);
		cyc((hi + lo) * 21);
		chk(hi_n, hi * 10);
		chk(lo_n, lo * 10);
	endtask
	initial begin
		cyc(5);
		reset = 0;
		chk(report_port_sel, 1);
		levels;
		cfg;
		ring(0);
		ring(300);
		blink(3'h3, 125, 125);
		blink(3'h1, 200, 1800);
		blink(3'h2, 1800, 200);
		act_state = 3'h4;
		cyc(30);
		chk(activity_blink_output, 1);
		close_out;
	end
endmodule
`default_nettype wire

// ---- verilog/sio_map.vh ----
// Constants for the status indicator outputs block.
// Assumes a 50 MHz reference clock.
`ifndef SIO_MAP_VH
`define SIO_MAP_VH
`define SIO_CLK_HZ 50000000
`define SIO_TICK_NS 1000000
`define SIO_CLK_PERIOD_NS 20
`define SIO_SEARCH_HI_MS 200
`define SIO_SEARCH_LO_MS 1800
`define SIO_IDLE_HI_MS 1800
`define SIO_IDLE_LO_MS 200
`define SIO_DATA_HI_MS 125
`define SIO_DATA_LO_MS 125
`define SIO_RING_LOW_MS 120
// Activity state encoding on the act_state input
`define SIO_ACT_OFF 3'h0
`define SIO_ACT_SEARCH 3'h1
`define SIO_ACT_IDLE 3'h2
`define SIO_ACT_DATA 3'h3
`define SIO_ACT_VOICE 3'h4
// Report port select encoding
`define SIO_PORT_SERIAL 2'h0
`define SIO_PORT_USB_CMD 2'h1
`define SIO_PORT_USB_MODEM 2'h2
// Ring behaviour encoding
`define SIO_RING_PULSE 2'h0
`define SIO_RING_ALWAYS_HI 2'h1
`define SIO_RING_ALWAYS_LO 2'h2
`endif

// ---- verilog/sio_status_ind.v ----
// Status indication outputs: registration mode, activity blink, power status, ring.
// Assumes state inputs and report strobes are synchronous to ref_clk.
`include "sio_map.vh"
`default_nettype none
module sio_status_ind #(
	parameter TICK_CYCLES = (`SIO_TICK_NS + `SIO_CLK_PERIOD_NS - 1) / `SIO_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Module state
	input wire powered_on,
	input wire lte_registered,
	input wire [2:0] act_state,
	// Report sources, one-cycle strobes
	input wire report_serial,
	input wire report_usb_cmd,
	input wire report_usb_modem,
	// Configuration command
	input wire cfg_wr,
	input wire [1:0] cfg_port,
	input wire [1:0] cfg_ring_mode,
	// Indicator outputs
	output reg registration_mode_indicator,
	output reg activity_blink_output,
	output reg operation_status_output,
	output reg ring_indicator_output,
	output reg [1:0] report_port_sel
);
	localparam ST_HI = 2'b01;
	localparam ST_LO = 2'b10;

	wire tick;
	reg [1:0] ring_mode_q;
	reg [2:0] act_prev_q;
	reg [1:0] ph_q;
	reg [11:0] ph_cnt_q;
	reg [11:0] hi_len;
	reg [11:0] lo_len;
	reg blinking;
	reg [7:0] ring_cnt_q;
	wire report_any;

	sio_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.reset(reset),
		.tick(tick)
	);

	// Phase lengths in ms for each activity state
	always @* begin
		blinking = 1'b1;
		case (act_state)
			`SIO_ACT_SEARCH: begin
				hi_len = 12'd`SIO_SEARCH_HI_MS;
				lo_len = 12'd`SIO_SEARCH_LO_MS;
			end
			`SIO_ACT_IDLE: begin
				hi_len = 12'd`SIO_IDLE_HI_MS;
				lo_len = 12'd`SIO_IDLE_LO_MS;
			end
			`SIO_ACT_DATA: begin
				hi_len = 12'd`SIO_DATA_HI_MS;
				lo_len = 12'd`SIO_DATA_LO_MS;
			end
			default: begin
				hi_len = 12'h001;
				lo_len = 12'h001;
				blinking = 1'b0;
			end
		endcase
	end

	// Status levels and configuration
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			registration_mode_indicator <= 1'b0;
			operation_status_output <= 1'b0;
			report_port_sel <= `SIO_PORT_USB_CMD;
			ring_mode_q <= `SIO_RING_PULSE;
		end else begin
			registration_mode_indicator <= powered_on & lte_registered;
			operation_status_output <= powered_on;
			if (cfg_wr) begin
				// Unused port code keeps the previous routing
				if (cfg_port != 2'h3)
					report_port_sel <= cfg_port;
				ring_mode_q <= cfg_ring_mode;
			end
		end
	end

	// Activity blink sequencer
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			act_prev_q <= `SIO_ACT_OFF;
			ph_q <= ST_HI;
			ph_cnt_q <= 12'h000;
			activity_blink_output <= 1'b0;
		end else begin
			act_prev_q <= act_state;
			if (act_state != act_prev_q) begin
				ph_q <= ST_HI;
				ph_cnt_q <= 12'h000;
			end else if (tick && blinking) begin
				case (ph_q)
					ST_HI: begin
						if (ph_cnt_q >= hi_len - 12'h001) begin
							ph_q <= ST_LO;
							ph_cnt_q <= 12'h000;
						end else
							ph_cnt_q <= ph_cnt_q + 12'h001;
					end
					ST_LO: begin
						if (ph_cnt_q >= lo_len - 12'h001) begin
							ph_q <= ST_HI;
							ph_cnt_q <= 12'h000;
						end else
							ph_cnt_q <= ph_cnt_q + 12'h001;
					end
					default: begin
						ph_q <= ST_HI;
						ph_cnt_q <= 12'h000;
					end
				endcase
			end
			if (!powered_on)
				activity_blink_output <= 1'b0;
			else if (act_state == `SIO_ACT_VOICE)
				activity_blink_output <= 1'b1;
			else if (blinking)
				activity_blink_output <= (act_state == act_prev_q) ? (ph_q == ST_HI) : 1'b1;
			else
				activity_blink_output <= 1'b0;
		end
	end

	// Any port's report counts, not only the routed one
	assign report_any = report_serial | report_usb_cmd | report_usb_modem;

	// Ring pulse timer
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ring_cnt_q <= 8'h00;
			ring_indicator_output <= 1'b1;
		end else begin
			// One extra tick absorbs the partial first tick, so the pulse never runs short
			if (report_any && ring_mode_q != `SIO_RING_ALWAYS_HI && ring_mode_q != `SIO_RING_ALWAYS_LO)
				ring_cnt_q <= 8'd`SIO_RING_LOW_MS + 8'h01;
			else if (tick && ring_cnt_q != 8'h00)
				ring_cnt_q <= ring_cnt_q - 8'h01;
			case (ring_mode_q)
				`SIO_RING_ALWAYS_HI: ring_indicator_output <= 1'b1;
				`SIO_RING_ALWAYS_LO: ring_indicator_output <= 1'b0;
				default: ring_indicator_output <= !(report_any || ring_cnt_q != 8'h00);
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- verilog/sio_tick_div.v ----
// Millisecond tick divider: one-cycle enable every TICK_CYCLES clocks.
// Assumes ref_clk is the single system clock.
`default_nettype none
module sio_tick_div #(
	parameter TICK_CYCLES = 50000
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Tick
	output reg tick
);
	reg [31:0] cnt_q;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_q >= TICK_CYCLES - 1) begin
			cnt_q <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire
